/* File: inc/cma_pkg.sv */
// Package of constants and types for the configurable multiply, divide and shift unit.
package cma_pkg;

  localparam int DATA_W = 32;

  typedef enum logic [1:0] {
    MUL_NONE = 2'h0,
    MUL_LE   = 2'h1,
    MUL_DSP  = 2'h2,
    MUL_EMB  = 2'h3
  } cma_mul_type;

  typedef enum logic [3:0] {
    OP_ADD    = 4'h0,
    OP_ADDI   = 4'h1,
    OP_MUL    = 4'h2,
    OP_MULI   = 4'h3,
    OP_MULXSS = 4'h4,
    OP_MULXSU = 4'h5,
    OP_MULXUU = 4'h6,
    OP_DIV    = 4'h7,
    OP_DIVU   = 4'h8,
    OP_SLL    = 4'h9,
    OP_SRL    = 4'ha,
    OP_SRA    = 4'hb,
    OP_ROL    = 4'hc,
    OP_ROR    = 4'hd
  } cma_op_type;

  // Cycles between accepted operations per multiplier option.
  localparam logic [6:0] CPI_LE  = 7'h0b;
  localparam logic [6:0] CPI_DSP = 7'h01;
  localparam logic [6:0] CPI_EMB = 7'h05;
  // Extra cycles from the end of execution until the result is written back.
  localparam logic [6:0] RES_LAT = 7'h02;
  // Divider bounds: the quickest and the slowest divide.
  localparam logic [6:0] DIV_MIN = 7'h04;
  localparam logic [6:0] DIV_MAX = 7'h42;
  // Shift latency on the multiplier path.
  localparam logic [6:0] SHF_MUL = 7'h02;
  localparam logic [6:0] CNT_ZERO = 7'h00;

endpackage

/* File: verilog/cma_divider.sv */
// Multicycle radix-2 restoring divider built from general logic.
`timescale 1ns/1ps
module cma_divider
  import cma_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              start,
  input  wire logic              signedOp,
  input  wire logic [DATA_W-1:0] dividend,
  input  wire logic [DATA_W-1:0] divisor,
  output logic                   done,
  output logic [DATA_W-1:0]      quotient
);

  logic [DATA_W-1:0] rem_r;
  logic [DATA_W-1:0] quo_r;
  logic [DATA_W-1:0] dsr_r;
  logic [6:0]        cnt_r;
  logic              neg_r;
  logic              busy_r;
  logic [DATA_W:0]   trial;
  logic [DATA_W-1:0] absA;
  logic [DATA_W-1:0] absB;

  assign absA  = (signedOp && dividend[DATA_W-1]) ? -dividend : dividend;
  assign absB  = (signedOp && divisor[DATA_W-1]) ? -divisor : divisor;
  assign trial = {rem_r, quo_r[DATA_W-1]} - {1'b0, dsr_r};

  // Leading zero bits of the dividend are skipped a nibble at a time, so small operands finish near the
  // quickest time, while a full-width dividend walks all 32 bits plus the fixed setup steps.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rem_r  <= '0;
      quo_r  <= '0;
      dsr_r  <= '0;
      cnt_r  <= CNT_ZERO;
      neg_r  <= 1'b0;
      busy_r <= 1'b0;
      done   <= 1'b0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy_r) begin
        rem_r  <= '0;
        quo_r  <= absA;
        dsr_r  <= absB;
        neg_r  <= signedOp && (dividend[DATA_W-1] ^ divisor[DATA_W-1]);
        cnt_r  <= 7'(DATA_W);
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (cnt_r > 7'h04 && rem_r == '0 && quo_r[DATA_W-1 -: 4] == 4'h0) begin
          quo_r <= quo_r << 4;
          cnt_r <= cnt_r - 7'h04;
        end else if (cnt_r != CNT_ZERO) begin
          if (!trial[DATA_W]) begin
            rem_r <= trial[DATA_W-1:0];
            quo_r <= {quo_r[DATA_W-2:0], 1'b1};
          end else begin
            rem_r <= {rem_r[DATA_W-2:0], quo_r[DATA_W-1]};
            quo_r <= {quo_r[DATA_W-2:0], 1'b0};
          end
          cnt_r <= cnt_r - 7'h01;
        end else begin
          quotient <= neg_r ? -quo_r : quo_r;
          done     <= 1'b1;
          busy_r   <= 1'b0;
        end
      end
    end
  end

endmodule

/* File: verilog/cma_alu.sv */
// Top of the configurable multiply, divide and shift unit with its issue interlock.
//
// Contract
// RULE_01: With no multiply or divide hardware every multiply and divide raises an exception instead of a result.
// RULE_02: The logic-element multiplier is 32 by 4 bits, accepts one operation per 11 cycles, adds 2 latency, low word only.
// RULE_03: The dedicated multiplier is 32 by 32 bits, one per cycle, 2 latency, with low word and all high-word variants; the code takes one per 3 cycles.
// RULE_04: The embedded multiplier is 32 by 16 bits, one per 5 cycles, 2 latency, low word only.
// RULE_05: The optional divider is multicycle general logic for signed and unsigned divide, 4 to 66 cycles plus 2 latency.
// RULE_06: No operation of a kind is accepted more often than that option's cycles-per-instruction figure.
// RULE_07: An instruction that reads a pending multiply or divide result stalls until that result is ready.
// RULE_08: Instructions that do not depend on a pending result proceed without stalling; the code lets only ADD and ADDI pass, others wait for ST_IDLE.
// RULE_09: Ordinary arithmetic completes in one cycle when no operand waits on a pending result.
// RULE_10: With a hardware multiplier, shifts and rotates run on the multiplier path in one or two cycles.
// RULE_11: Without a hardware multiplier, a dedicated shifter moves one bit per cycle for shifts and rotates.
// RULE_12: The unit shows busy while a multicycle operation runs and a result-valid when a writeback value is ready.
`timescale 1ns/1ps
module cma_alu
  import cma_pkg::*;
#(
  parameter cma_mul_type MUL_OPT = MUL_DSP,
  parameter bit          HAS_DIV = 1'b1
)(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              issueValid,
  input  wire cma_op_type        issueOp,
  input  wire logic [DATA_W-1:0] opA,
  input  wire logic [DATA_W-1:0] opB,
  input  wire logic [4:0]        destReg,
  input  wire logic [4:0]        srcRegA,
  input  wire logic [4:0]        srcRegB,
  output logic                   issueReady,
  output logic                   busy,
  output logic                   resultValid,
  output logic [DATA_W-1:0]      resultData,
  output logic [4:0]             resultReg,
  output logic                   exception
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_LAT  = 4'b0100,
    ST_DIV  = 4'b1000
  } cma_state_type;

  function automatic logic isMul(input cma_op_type op);
    return op inside {OP_MUL, OP_MULI, OP_MULXSS, OP_MULXSU, OP_MULXUU};
  endfunction

  function automatic logic isShift(input cma_op_type op);
    return op inside {OP_SLL, OP_SRL, OP_SRA, OP_ROL, OP_ROR};
  endfunction

  function automatic logic mulSupported(input cma_op_type op);
    if (MUL_OPT == MUL_DSP) begin
      return isMul(op);
    end
    return (MUL_OPT != MUL_NONE) && (op == OP_MUL || op == OP_MULI);
  endfunction

  localparam logic [6:0] CPI = (MUL_OPT == MUL_LE) ? CPI_LE : (MUL_OPT == MUL_EMB) ? CPI_EMB : CPI_DSP;
  localparam int SLICE_W = (MUL_OPT == MUL_LE) ? 4 : (MUL_OPT == MUL_EMB) ? 16 : 32;

  cma_state_type     state_r;
  cma_op_type        op_r;
  logic [DATA_W-1:0] a_r;
  logic [DATA_W-1:0] b_r;
  logic [63:0]       acc_r;
  logic [6:0]        cnt_r;
  logic [6:0]        gap_r;
  logic [4:0]        pendReg_r;
  logic              divStart;
  logic              divDone;
  logic [DATA_W-1:0] divQuot;
  logic              hazard;
  logic              accept;
  logic              isDiv;
  logic              shortOp;
  logic              unsupported;
  logic [63:0]       fullProd;
  logic [DATA_W-1:0] slice;

  assign isDiv       = (issueOp == OP_DIV) || (issueOp == OP_DIVU);
  assign shortOp     = (issueOp == OP_ADD) || (issueOp == OP_ADDI);
  assign unsupported = (isMul(issueOp) && !mulSupported(issueOp)) || (isDiv && !HAS_DIV); // RULE_01
  // A pending writeback target blocks only the instructions that read it.
  assign hazard      = (state_r != ST_IDLE) && (srcRegA == pendReg_r || srcRegB == pendReg_r); // RULE_07 RULE_08
  // Single-cycle arithmetic may pass a long operation in flight; only a register hazard holds it back.
  assign issueReady  = ((state_r == ST_IDLE) && (gap_r == CNT_ZERO)) || shortOp; // RULE_06 RULE_08
  assign accept      = issueValid && issueReady && !hazard;
  assign busy        = (state_r != ST_IDLE); // RULE_12
  assign divStart    = accept && isDiv && !unsupported;

  // The full product serves the dedicated multiplier; the narrower options walk operand B by slices.
  // Operands are extended to the full product width first, so the upper word never depends on context sizing.
  assign fullProd = (op_r == OP_MULXSS) ? $signed({{32{a_r[31]}}, a_r}) * $signed({{32{b_r[31]}}, b_r}) :
                    (op_r == OP_MULXSU) ? $signed({{32{a_r[31]}}, a_r}) * $signed({32'h0, b_r}) :
                    {32'h0, a_r} * {32'h0, b_r}; // RULE_03
  assign slice    = DATA_W'(b_r[SLICE_W-1:0]);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_IDLE;
      op_r      <= OP_ADD;
      a_r       <= '0;
      b_r       <= '0;
      acc_r     <= '0;
      cnt_r     <= CNT_ZERO;
      pendReg_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (accept && !unsupported && (isMul(issueOp) || isShift(issueOp))) begin
            op_r      <= issueOp;
            a_r       <= opA;
            b_r       <= opB;
            acc_r     <= '0;
            pendReg_r <= destReg;
            state_r   <= ST_EXEC;
            if (isMul(issueOp)) begin
              cnt_r <= (MUL_OPT == MUL_DSP) ? CNT_ZERO : 7'(DATA_W / SLICE_W - 1); // RULE_02 RULE_04
            end else begin
              cnt_r <= (MUL_OPT != MUL_NONE) ? CNT_ZERO : 7'({2'b00, opB[4:0]}); // RULE_10 RULE_11
            end
          end else if (divStart) begin
            op_r      <= issueOp;
            pendReg_r <= destReg;
            state_r   <= ST_DIV; // RULE_05
          end
        end
        ST_EXEC: begin
          if (isMul(op_r)) begin
            if (MUL_OPT == MUL_DSP) begin
              acc_r <= (op_r inside {OP_MUL, OP_MULI}) ? fullProd : {fullProd[63:32], 32'h0};
            end else begin
              acc_r <= acc_r + ((64'(a_r) * 64'(slice)) << (7'(DATA_W / SLICE_W - 1) - cnt_r) * SLICE_W);
              b_r   <= b_r >> SLICE_W;
            end
          end else if (MUL_OPT != MUL_NONE) begin
            // The barrel form stands in for the multiplier path of a two-cycle shift.
            case (op_r)
              OP_SLL:  acc_r <= 64'(a_r << b_r[4:0]);
              OP_SRL:  acc_r <= 64'(a_r >> b_r[4:0]);
              OP_SRA:  acc_r <= 64'($unsigned($signed(a_r) >>> b_r[4:0]));
              OP_ROL:  acc_r <= 64'((a_r << b_r[4:0]) | (a_r >> (6'h20 - {1'b0, b_r[4:0]})));
              default: acc_r <= 64'((a_r >> b_r[4:0]) | (a_r << (6'h20 - {1'b0, b_r[4:0]})));
            endcase // RULE_10
          end else if (cnt_r != CNT_ZERO) begin
            case (op_r)
              OP_SLL:  a_r <= {a_r[DATA_W-2:0], 1'b0};
              OP_SRL:  a_r <= {1'b0, a_r[DATA_W-1:1]};
              OP_SRA:  a_r <= {a_r[DATA_W-1], a_r[DATA_W-1:1]};
              OP_ROL:  a_r <= {a_r[DATA_W-2:0], a_r[DATA_W-1]};
              default: a_r <= {a_r[0], a_r[DATA_W-1:1]};
            endcase // RULE_11
          end else begin
            acc_r <= 64'(a_r);
          end
          if (cnt_r != CNT_ZERO) begin
            cnt_r <= cnt_r - 7'h01;
          end else begin
            // The writeback register is the last latency cycle, so the counter stops one short of it.
            cnt_r   <= (isShift(op_r) && MUL_OPT != MUL_NONE) ? SHF_MUL - 7'h02 : RES_LAT - 7'h02;
            state_r <= ST_LAT;
          end
        end
        ST_LAT: begin
          if (cnt_r != CNT_ZERO) begin
            cnt_r <= cnt_r - 7'h01;
          end else if (!(accept && shortOp)) begin
            // A single-cycle result owns the writeback port this cycle; the long result waits one more.
            state_r <= ST_IDLE; // RULE_08
          end
        end
        ST_DIV: begin
          if (divDone) begin
            acc_r   <= 64'(divQuot);
            cnt_r   <= RES_LAT - 7'h02;
            state_r <= ST_LAT;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Spacing counter for the narrow multipliers; it runs from acceptance so writeback rate matches issue.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gap_r <= CNT_ZERO;
    end else if (accept && isMul(issueOp) && !unsupported) begin
      gap_r <= CPI - 7'h01; // RULE_06
    end else if (gap_r != CNT_ZERO) begin
      gap_r <= gap_r - 7'h01;
    end
  end

  // Writeback: single-cycle arithmetic returns at once; long operations return when the latency ends.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      resultValid <= 1'b0;
      resultData  <= '0;
      resultReg   <= '0;
      exception   <= 1'b0;
    end else begin
      resultValid <= 1'b0;
      exception   <= 1'b0;
      if (accept && unsupported) begin
        exception <= 1'b1; // RULE_01
      end else if (accept && shortOp) begin
        resultValid <= 1'b1;
        resultData  <= opA + opB;
        resultReg   <= destReg; // RULE_09
      end else if (state_r == ST_LAT && cnt_r == CNT_ZERO) begin
        resultValid <= 1'b1;
        resultData  <= (op_r inside {OP_MULXSS, OP_MULXSU, OP_MULXUU}) ? acc_r[63:32] : acc_r[31:0];
        resultReg   <= pendReg_r; // RULE_12
      end
    end
  end

  cma_divider u_div (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .start    (divStart),
    .signedOp (issueOp == OP_DIV),
    .dividend (opA),
    .divisor  (opB),
    .done     (divDone),
    .quotient (divQuot)
  );

  AST_UNSUP_EXC: assert property (@(posedge sys_clk) disable iff (rst)
    issueValid && issueReady && !hazard && unsupported |=> exception && !resultValid) // RULE_01
    else $error("Unsupported operation did not raise an exception.");

  AST_ADD_ONE: assert property (@(posedge sys_clk) disable iff (rst)
    accept && issueOp == OP_ADD |=> resultValid && resultData == $past(opA) + $past(opB)) // RULE_09
    else $error("Add did not complete in one cycle.");

  AST_HAZ_STALL: assert property (@(posedge sys_clk) disable iff (rst)
    busy && issueValid && (srcRegA == pendReg_r) |-> !accept) // RULE_07
    else $error("Dependent instruction issued during a pending result.");

  AST_INDEP_GO: assert property (@(posedge sys_clk) disable iff (rst)
    issueValid && shortOp && !hazard |-> accept) // RULE_08
    else $error("Independent instruction stalled.");

  sequence seqMulAccept;
    accept && isMul(issueOp) && !unsupported;
  endsequence

  AST_MUL_GAP: assert property (@(posedge sys_clk) disable iff (rst)
    seqMulAccept |=> (gap_r == CPI - 7'h01) && !(accept && isMul(issueOp))) // RULE_06
    else $error("Multiply accepted faster than its issue rate.");

  AST_DSP_LAT: assert property (@(posedge sys_clk) disable iff (rst)
    seqMulAccept and (MUL_OPT == MUL_DSP) |-> ##3 resultValid) // RULE_03
    else $error("Dedicated multiply result not after two latency cycles.");

  AST_DIV_BOUND: assert property (@(posedge sys_clk) disable iff (rst)
    divStart |-> ##[4:72] resultValid) // RULE_05
    else $error("Divide result outside its cycle bounds.");

  AST_BUSY_TIL: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(busy) |-> busy until resultValid) // RULE_12
    else $error("Busy dropped before the result was valid.");

endmodule

/* File: tb/cma_issue_model.sv */
// Issue stage model that offers instructions and holds each one until the unit takes it.
`timescale 1ns/1ps
module cma_issue_model
  import cma_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              issueReady,
  input  wire logic              busy,
  output logic                   issueValid,
  output cma_op_type             issueOp,
  output logic [DATA_W-1:0]      opA,
  output logic [DATA_W-1:0]      opB,
  output logic [4:0]             destReg,
  output logic [4:0]             srcRegA,
  output logic [4:0]             srcRegB
);
  logic [4:0] pendReg;
  logic       hung;

  initial begin
    issueValid = 1'b0;
    issueOp = OP_ADD;
    opA = 32'h0;
    opB = 32'h0;
    destReg = 5'h0;
    srcRegA = 5'h0;
    srcRegB = 5'h0;
    pendReg = 5'h0;
    hung = 1'b0;
  end

  // The request stays up until an edge where it can be taken, so a refused offer is never lost.
  task automatic send(input cma_op_type op, input logic [DATA_W-1:0] a, b, input logic [4:0] d, sa, sb);
    int   i;
    logic tk;
    @(negedge sys_clk);
    issueValid = 1'b1;
    issueOp = op;
    opA = a;
    opB = b;
    destReg = d;
    srcRegA = sa;
    srcRegB = sb;
    for (i = 0; i < 200; i++) begin
      #1;
      tk = issueReady && !(busy && (sa == pendReg || sb == pendReg));
      @(posedge sys_clk);
      if (tk) break;
      @(negedge sys_clk);
    end
    if (i == 200) hung = 1'b1;
    if (op != OP_ADD && op != OP_ADDI) pendReg = d;
  endtask

  task automatic idle();
    @(negedge sys_clk);
    issueValid = 1'b0;
  endtask
endmodule

/* File: tb/cma_alu_tb.sv */
// Self-checking bench for the configurable multiply, divide and shift unit.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t %h %h", $time, g, e); end end
module cma_alu_tb
  import cma_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst = 1'b1;
  logic              sel = 1'b0;
  int                n_errors = 0;
  int                n_compared = 0;
  logic              mValid;
  cma_op_type        mOp;
  logic [DATA_W-1:0] mA;
  logic [DATA_W-1:0] mB;
  logic [4:0]        mD;
  logic [4:0]        mSa;
  logic [4:0]        mSb;
  logic              rdy [2];
  logic              bsy [2];
  logic              rv [2];
  logic              ex [2];
  logic [DATA_W-1:0] rd [2];
  logic [4:0]        rr [2];
  cma_op_type        mOps [5] = '{OP_MUL, OP_MULI, OP_MULXSS, OP_MULXSU, OP_MULXUU};
  logic [31:0]       mAs [5] = '{32'h7, 32'h3, 32'hffffffff, 32'hffffffff, 32'hffffffff};
  logic [31:0]       mBs [5] = '{32'h6, 32'h9, 32'hffffffff, 32'h2, 32'h2};
  logic [31:0]       mRes [5] = '{32'h2a, 32'h1b, 32'h0, 32'hffffffff, 32'h1};
  cma_op_type        sOps [5] = '{OP_SLL, OP_SRL, OP_SRA, OP_ROL, OP_ROR};
  logic [31:0]       sRes [5] = '{32'h110, 32'h08000001, 32'hf8000001, 32'h118, 32'h18000001};
  cma_op_type        xOps [4] = '{OP_MUL, OP_MULXUU, OP_DIV, OP_DIVU};

  always #2.5 sys_clk = ~sys_clk;

  cma_issue_model m (.sys_clk(sys_clk), .issueReady(rdy[sel]), .busy(bsy[sel]), .issueValid(mValid), .issueOp(mOp),
    .opA(mA), .opB(mB), .destReg(mD), .srcRegA(mSa), .srcRegB(mSb));
  cma_alu #(.MUL_OPT(MUL_DSP), .HAS_DIV(1'b1)) dut (.sys_clk(sys_clk), .rst(rst), .issueValid(mValid & ~sel),
    .issueOp(mOp), .opA(mA), .opB(mB), .destReg(mD), .srcRegA(mSa), .srcRegB(mSb), .issueReady(rdy[0]),
    .busy(bsy[0]), .resultValid(rv[0]), .resultData(rd[0]), .resultReg(rr[0]), .exception(ex[0]));
  // Second build without multiply or divide hardware, so the serial shifter and the traps are reached.
  cma_alu #(.MUL_OPT(MUL_NONE), .HAS_DIV(1'b0)) dut_none (.sys_clk(sys_clk), .rst(rst), .issueValid(mValid & sel),
    .issueOp(mOp), .opA(mA), .opB(mB), .destReg(mD), .srcRegA(mSa), .srcRegB(mSb), .issueReady(rdy[1]),
    .busy(bsy[1]), .resultValid(rv[1]), .resultData(rd[1]), .resultReg(rr[1]), .exception(ex[1]));

  task automatic finish_test();
    if (m.hung) n_errors++;
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wres(output int n);
    for (n = 1; n <= 80; n++) begin
      if (rv[sel] === 1'b1 || ex[sel] === 1'b1) return;
      @(posedge sys_clk);
      #1;
    end
    n_errors++;
    finish_test();
  endtask

  task automatic go(input cma_op_type op, input logic [31:0] a, b, input logic [4:0] d, output int n);
    m.send(op, a, b, d, 5'h02, 5'h03);
    m.idle();
    if (m.hung) finish_test();
    if (!sel && op != OP_ADD && op != OP_ADDI) `CHK({bsy[0], rdy[0]}, 2'b10)
    wres(n);
  endtask

  task automatic s_mul();
    int n;
    for (int i = 0; i < 5; i++) begin
      go(mOps[i], mAs[i], mBs[i], 5'(i + 4), n);
      `CHK({rd[0], rr[0], rv[0]}, {mRes[i], 5'(i + 4), 1'b1})
      `CHK(n, 3)
    end
  endtask

  task automatic s_add_div();
    int n;
    go(OP_ADDI, 32'h5, 32'h64, 5'h8, n);
    `CHK({rd[0], n}, {32'h69, 32'd1})
    go(OP_ADD, 32'hffffffff, 32'h1, 5'h8, n);
    `CHK({rd[0], n}, {32'h0, 32'd1})
    go(OP_DIV, 32'hffffff9c, 32'h7, 5'ha, n);
    `CHK({rd[0], (n inside {[6:68]})}, {32'hfffffff2, 1'b1})
    go(OP_DIVU, 32'h64, 32'h7, 5'ha, n);
    `CHK({rd[0], (n inside {[6:68]})}, {32'he, 1'b1})
  endtask

  task automatic s_dep();
    time t0;
    int  n;
    m.send(OP_MUL, 32'h3, 32'h4, 5'h1, 5'h2, 5'h3);
    t0 = $time;
    m.send(OP_ADDI, 32'hc, 32'h64, 5'h1, 5'h1, 5'h3);
    `CHK((($time - t0) == 15), 1'b1)
    m.idle();
    wres(n);
    `CHK(rd[0], 32'h70)
    m.send(OP_MUL, 32'h3, 32'h4, 5'h1, 5'h2, 5'h3);
    t0 = $time;
    m.send(OP_ADD, 32'h1, 32'h2, 5'h8, 5'h5, 5'h6);
    `CHK((($time - t0) == 5), 1'b1)
    m.idle();
    wres(n);
    `CHK({rd[0], rr[0]}, {32'h3, 5'h8})
    @(negedge sys_clk);
    wres(n);
    `CHK({rd[0], rr[0]}, {32'hc, 5'h1})
  endtask

  task automatic s_shift(input logic which);
    int n;
    sel = which;
    for (int i = 0; i < 5; i++) begin
      go(sOps[i], 32'h80000011, 32'h4, 5'h9, n);
      `CHK(rd[sel], sRes[i])
      if (which) `CHK((n >= 4), 1'b1)
      else `CHK((n <= 3), 1'b1)
    end
  endtask

  task automatic s_none();
    int n;
    sel = 1'b1;
    for (int i = 0; i < 4; i++) begin
      go(xOps[i], 32'h6, 32'h3, 5'h7, n);
      `CHK({ex[1], rv[1], (n == 1)}, 3'b101)
    end
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    s_mul();
    s_add_div();
    s_dep();
    s_shift(1'b0);
    s_shift(1'b1);
    s_none();
    finish_test();
  end
endmodule
